// ===== common/sop_pkg.sv
/*
 * Constants for the programmable sum-of-products array: array geometry,
 * product-term grouping, output mixes and power-up register values.
 * Assumes nothing of its surroundings; shared by the design and bench.
 */
`default_nettype none

package sop_pkg;

    // ****************************************************************
    // Array geometry
    // ****************************************************************
    localparam int N_IN = 20;
    localparam int N_LINE = 2 * N_IN;
    localparam int N_TERM = 64;
    localparam int N_CELL = N_LINE * N_TERM;
    localparam int N_OUT = 8;
    localparam int GRP = 8;
    localparam int N_DED = 12;
    localparam int N_DED_PIN = 14;

    // ****************************************************************
    // Product-term use inside a group
    // ****************************************************************
    localparam int N_SUM_COMB = 7;
    localparam int EN_TERM = 7;

    // ****************************************************************
    // Output mixes (registered output count)
    // ****************************************************************
    localparam int MIX_R0 = 0;
    localparam int MIX_R4 = 4;
    localparam int MIX_R6 = 6;
    localparam int MIX_R8 = 8;

    // All-combinatorial mix: outputs without pin feedback
    localparam int NOFB_LO = 0;
    localparam int NOFB_HI = 7;
    localparam int EXTRA_DED_LO = 12;
    localparam int EXTRA_DED_HI = 13;

    // ****************************************************************
    // Power-up register state per variant
    // ****************************************************************
    localparam logic [7:0] Q_INIT_LINK = 8'hFF;
    localparam logic [7:0] Q_INIT_VERT = 8'h00;

    // Synchroniser width: ded, pin, clk, oe, supply, load, clear, data
    localparam int N_SYNC = N_DED_PIN + N_OUT + 5 + N_OUT;

endpackage : sop_pkg

`default_nettype wire

// ===== logic/sop_array.sv
/*
 * Programmable sum-of-products array with eight active-low three-state
 * outputs, a selectable mix of registered and combinatorial outputs,
 * register feedback and test preload.
 * Assumes: all pins arrive asynchronous to core_clk and are resynchronised;
 * the connection map is static configuration on the core_clk domain;
 * the board resolves each pin from pin_out and pin_oe.
 */
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - AND array of 20 input pairs by 64 terms, a cell per crossing.
// - Eight groups of eight terms; combinatorial ORs seven, registered eight.
// - A term is true only while every connected line is high.
// - Both polarities of one input connected holds the term false.
// - A term with nothing connected is always true.
// - Output mix has zero, four, six or eight registered outputs.
// - Every pin drives the inverse of its function and can float.
// - Eighth term of a combinatorial group enables its driver.
// - Combinatorial pins feed back, except two in the all-combinatorial mix.
// - An enable term that is never true leaves the pin an input.
// - Each registered output ORs eight terms into a flip-flop.
// - All flip-flops load together on the device clock rising edge.
// - Registered drivers share one active-low enable pin.
// - Flip-flop state feeds back internally even while drivers are off.
// - Fuse-link variant powers up with every flip-flop set.
// - Vertical-fuse variant powers up with every flip-flop cleared.
// - Vertical-fuse outputs float while supply is below about 3V.
// - Unprogrammed vertical-fuse part drives low and sets flops on first edge.
// - Toggling an unconnected input changes no output.
// - Test preload may load any state into the flip-flops.
// - Vertical-fuse registered outputs reach high within power-up time.
module sop_array #(
    parameter int N_REG = sop_pkg::MIX_R4,
    parameter bit VERT_FUSE = 1'b1
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic dev_clk,
    input wire logic oe_b,
    input wire logic [sop_pkg::N_DED_PIN-1:0] ded_in,
    input wire logic [sop_pkg::N_OUT-1:0] pin_in,
    input wire logic supply_ok,
    input wire logic pl_load,
    input wire logic pl_clear,
    input wire logic [sop_pkg::N_OUT-1:0] pl_data,
    input wire logic [sop_pkg::N_CELL-1:0] cfg_fuse,
    output logic [sop_pkg::N_OUT-1:0] pin_out,
    output logic [sop_pkg::N_OUT-1:0] pin_oe
);

    // ****************************************************************
    // Output mix decode
    // ****************************************************************
    function automatic logic [7:0] reg_mask_f(input int n);
        logic [7:0] m;
        m = 8'h00;
        for (int k = 0; k < sop_pkg::N_OUT; k++) begin
            m[k] = (k >= (sop_pkg::N_OUT - n) / 2) &&
                   (k < (sop_pkg::N_OUT + n) / 2);
        end
        return m;
    endfunction : reg_mask_f

    // Registered outputs sit in the middle of the pin row
    localparam logic [7:0] REG_MASK = reg_mask_f(N_REG);
    localparam logic [7:0] Q_INIT = VERT_FUSE ? sop_pkg::Q_INIT_VERT
                                              : sop_pkg::Q_INIT_LINK;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [sop_pkg::N_SYNC-1:0] sync_raw;
    logic [sop_pkg::N_SYNC-1:0] sync1_r;
    logic [sop_pkg::N_SYNC-1:0] sync2_r;

    assign sync_raw = {pl_data, pl_clear, pl_load, supply_ok, oe_b,
                       dev_clk, pin_in, ded_in};

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= sync_raw;
            sync2_r <= sync1_r;
        end
    end

    logic [sop_pkg::N_DED_PIN-1:0] s_ded;
    logic [sop_pkg::N_OUT-1:0] s_pin;
    logic s_clk;
    logic s_oe_b;
    logic s_supply;
    logic s_load;
    logic s_clear;
    logic [sop_pkg::N_OUT-1:0] s_data;

    assign {s_data, s_clear, s_load, s_supply, s_oe_b, s_clk, s_pin,
            s_ded} = sync2_r;

    // ****************************************************************
    // Array inputs and feedback
    // ****************************************************************
    logic [7:0] q_r;
    logic [7:0] q_nxt;
    logic [7:0] fb;
    logic [7:0] fb_eff;
    logic [sop_pkg::N_IN-1:0] arr_in;
    logic [sop_pkg::N_LINE-1:0] lines;

    // Registered groups read the flop, not the pin, so they keep
    // sequencing while the shared enable is off
    assign fb = (REG_MASK & q_r) | (~REG_MASK & s_pin);

    generate
        if (N_REG == sop_pkg::MIX_R0) begin : g_nofb
            always_comb begin
                fb_eff = fb;
                fb_eff[sop_pkg::NOFB_LO] = s_ded[sop_pkg::EXTRA_DED_LO];
                fb_eff[sop_pkg::NOFB_HI] = s_ded[sop_pkg::EXTRA_DED_HI];
            end
        end else begin : g_fb
            assign fb_eff = fb;
        end
    endgenerate

    assign arr_in = {fb_eff, s_ded[sop_pkg::N_DED-1:0]};

    genvar gi;
    generate
        for (gi = 0; gi < sop_pkg::N_IN; gi++) begin : g_line
            assign lines[2*gi] = arr_in[gi];
            assign lines[2*gi+1] = ~arr_in[gi];
        end
    endgenerate

    // ****************************************************************
    // AND array
    // ****************************************************************
    // A disconnected line is forced high; an empty term is thus true and
    // a term holding both phases of one input can never be true
    logic [sop_pkg::N_TERM-1:0] term;

    generate
        for (gi = 0; gi < sop_pkg::N_TERM; gi++) begin : g_term
            assign term[gi] = &(lines |
                ~cfg_fuse[gi*sop_pkg::N_LINE +: sop_pkg::N_LINE]);
        end
    endgenerate

    // ****************************************************************
    // OR groups
    // ****************************************************************
    logic [7:0] comb_sum;
    logic [7:0] comb_en;
    logic [7:0] reg_d;

    generate
        for (gi = 0; gi < sop_pkg::N_OUT; gi++) begin : g_grp
            assign comb_sum[gi] =
                |term[gi*sop_pkg::GRP +: sop_pkg::N_SUM_COMB];
            assign comb_en[gi] =
                term[gi*sop_pkg::GRP + sop_pkg::EN_TERM];
            assign reg_d[gi] = |term[gi*sop_pkg::GRP +: sop_pkg::GRP];
        end
    endgenerate

    // ****************************************************************
    // Flip-flops
    // ****************************************************************
    logic clk_d_r;
    logic clk_edge;
    logic pl_clear_act;
    logic pl_any;

    // Edge seen on synchronised pin; assumes the board keeps it still
    // until power-up init ends
    assign clk_edge = s_clk & ~clk_d_r;
    assign pl_clear_act = VERT_FUSE & s_clear;
    assign pl_any = s_load | pl_clear_act;

    // Clear wins over load: the clear pin overrides data on the pins
    assign q_nxt = pl_clear_act ? 8'h00 :
                   s_load ? (REG_MASK & s_data) | (~REG_MASK & q_r) :
                   clk_edge ? (REG_MASK & reg_d) | (~REG_MASK & q_r) :
                   q_r;

    // Reset is the power-up init: constant per variant
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            q_r <= Q_INIT;
            clk_d_r <= 1'b0;
        end else begin
            q_r <= q_nxt;
            clk_d_r <= s_clk;
        end
    end

    // ****************************************************************
    // Output drivers
    // ****************************************************************
    logic pwr_ok;
    logic [7:0] fn;
    logic [7:0] out_nxt;
    logic [7:0] oe_nxt;

    // Only the vertical-fuse variant watches the supply
    assign pwr_ok = !VERT_FUSE || s_supply;
    assign fn = (REG_MASK & q_r) | (~REG_MASK & comb_sum);
    assign out_nxt = ~fn;
    assign oe_nxt = {8{pwr_ok}} &
                    ((REG_MASK & {8{~s_oe_b}}) | (~REG_MASK & comb_en));

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_out <= 8'hFF;
            pin_oe <= 8'h00;
        end else begin
            pin_out <= out_nxt;
            pin_oe <= oe_nxt;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    a_reg_edge_load: assert property (
        clk_edge && !pl_any |=>
            (q_r & REG_MASK) == ($past(reg_d) & REG_MASK))
        else $error("registered bits missed the clock edge load");

    a_reg_no_edge: assert property (
        !clk_edge && !pl_any |=> q_r == $past(q_r))
        else $error("flip-flops changed without a clock edge");

    a_preload_load: assert property (
        s_load && !pl_clear_act |=>
            (q_r & REG_MASK) == ($past(s_data) & REG_MASK))
        else $error("preload data not taken");

    a_preload_keep: assert property (
        s_load && !pl_clear_act |=>
            (q_r & ~REG_MASK) == ($past(q_r) & ~REG_MASK))
        else $error("preload touched a combinatorial slot");

    a_clear_all: assert property (
        pl_clear_act |=> q_r == 8'h00)
        else $error("preload clear left a flop set");

    a_reg_oe_on: assert property (
        rst_b && !s_oe_b && pwr_ok |=> (pin_oe & REG_MASK) == REG_MASK)
        else $error("registered drivers off while enable low");

    a_reg_oe_off: assert property (
        s_oe_b |=> (pin_oe & REG_MASK) == 8'h00)
        else $error("registered drivers on while enable high");

    // Registered pins show the inverse of the flop state one edge later
    a_reg_pin_value: assert property (
        rst_b |=> (pin_out & REG_MASK) == (~$past(q_r) & REG_MASK))
        else $error("registered pin not inverse of flop");

    a_comb_oe: assert property (
        rst_b |=> (pin_oe & ~REG_MASK) ==
            ($past(comb_en) & ~REG_MASK & {8{$past(pwr_ok)}}))
        else $error("combinatorial enable not from its term");

    a_comb_pin_value: assert property (
        rst_b |=> (pin_out & ~REG_MASK) ==
            (~$past(comb_sum) & ~REG_MASK))
        else $error("combinatorial pin not inverse of sum");

    a_supply_float: assert property (
        !pwr_ok |=> pin_oe == 8'h00)
        else $error("driver on with supply low");

    // Cells of term 1; any input with both phases on kills it
    logic [sop_pkg::N_LINE-1:0] t1_cells;
    assign t1_cells = cfg_fuse[sop_pkg::N_LINE +: sop_pkg::N_LINE];

    a_term_conflict: assert property (
        |(t1_cells & (t1_cells >> 1) & {sop_pkg::N_IN{2'b01}}) |-> !term[1])
        else $error("term with both phases not false");

    a_term_empty: assert property (
        cfg_fuse[sop_pkg::N_LINE-1:0] == '0 |-> term[0])
        else $error("empty term not true");

    c_clock_load: cover property (clk_edge && !pl_any ##1 q_r != 8'h00);
    c_preload: cover property (s_load ##1 !s_load);
    c_comb_drive: cover property (pin_oe != 8'h00 && s_oe_b);
    c_reg_drive: cover property (!s_oe_b && pwr_ok ##1 pin_oe != 8'h00);
    c_clear: cover property (pl_clear_act ##1 q_r == 8'h00);

endmodule : sop_array

`default_nettype wire

// ===== tb/board_model.sv
/*
 * Board-side model of the sum-of-products array: device clock pulses
 * and resolution of the eight output pins with pull-ups.
 * Assumes core_clk runs free and the bench asks for clock pulses.
 */
`timescale 1ns/1ps
`default_nettype none

module board_model (
    input wire logic core_clk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output var logic dev_clk,
    output logic [7:0] pin_lvl
);
    // Released pins not driven via ext_en float up to the pull-up level, never hold old value
    assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en);

    // Clock stands low until a pulse is asked for
    initial dev_clk = 1'b0;

    // Four core cycles per phase so the synchroniser sees both levels
    task automatic clock_pulse(input int n);
        repeat (n) begin
            @(posedge core_clk);
            dev_clk <= 1'b1;
            repeat (4) @(posedge core_clk);
            dev_clk <= 1'b0;
            repeat (4) @(posedge core_clk);
        end
    endtask : clock_pulse
endmodule : board_model

`default_nettype wire

// ===== tb/programmable_sop_array_tb_top.sv
/*
 * Self-checking bench for the sum-of-products array, four registered
 * outputs (2..5), vertical-fuse variant, plus an all-registered
 * fuse-link copy on the same pins.
 * Assumes board_model and sop_pkg are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module programmable_sop_array_tb_top;
    logic core_clk, rst_b, oe_b, supply_ok, pl_load, pl_clear, dev_clk;
    logic [13:0] ded_in;
    logic [7:0] pl_data, pin_out, pin_oe, pin_lvl, ext_en, ext_val;
    logic [7:0] lnk_out, lnk_oe;
    logic [sop_pkg::N_CELL-1:0] cfg_fuse, fz;
    logic [23:0] exp_q[$];
    logic [15:0] exp_l[$];
    event chk_ev, chk_l;
    int n_fail, checked;

    always #2.5 core_clk = ~core_clk;

    sop_array #(.N_REG(sop_pkg::MIX_R4), .VERT_FUSE(1'b1)) u_dut (
        .core_clk(core_clk), .rst_b(rst_b), .dev_clk(dev_clk),
        .oe_b(oe_b), .ded_in(ded_in), .pin_in(pin_lvl),
        .supply_ok(supply_ok), .pl_load(pl_load), .pl_clear(pl_clear),
        .pl_data(pl_data), .cfg_fuse(cfg_fuse),
        .pin_out(pin_out), .pin_oe(pin_oe)
    );

    // Fuse-link, all-registered copy on the same pins
    sop_array #(.N_REG(sop_pkg::MIX_R8), .VERT_FUSE(1'b0)) u_dut_link (
        .core_clk(core_clk), .rst_b(rst_b), .dev_clk(dev_clk),
        .oe_b(oe_b), .ded_in(ded_in), .pin_in(pin_lvl),
        .supply_ok(supply_ok), .pl_load(pl_load), .pl_clear(pl_clear),
        .pl_data(pl_data), .cfg_fuse(cfg_fuse),
        .pin_out(lnk_out), .pin_oe(lnk_oe)
    );

    board_model u_board (
        .core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .ext_en(ext_en), .ext_val(ext_val), .dev_clk(dev_clk),
        .pin_lvl(pin_lvl)
    );

    // ****************************************************************
    // Expectation queue and output watcher
    // ****************************************************************
    // Settles well past the three-edge pin latency, then notes
    task automatic expect_out(input logic [7:0] out, oe, m);
        repeat (8) @(posedge core_clk);
        exp_q.push_back({m, oe, out & m});
        -> chk_ev;
    endtask : expect_out

    always begin : watcher
        logic [23:0] e;
        @(chk_ev);
        #1;
        e = exp_q.pop_front();
        checked++;
        if ({pin_oe, pin_out & e[23:16]} !== e[15:0]) begin
            n_fail++;
            $display("[ERR] t=%0t got %h exp %h", $time,
                {pin_oe, pin_out & e[23:16]}, e[15:0]);
        end
    end

    // Link copy is settled by the main check it follows
    task automatic expect_link(input logic [7:0] out, oe);
        exp_l.push_back({oe, out});
        -> chk_l;
    endtask : expect_link

    always begin : watch_link
        logic [15:0] e;
        @(chk_l);
        #1;
        e = exp_l.pop_front();
        checked++;
        if ({lnk_oe, lnk_out} !== e) begin
            n_fail++;
            $display("[ERR] t=%0t got %h exp %h", $time, {lnk_oe, lnk_out},
                e);
        end
    end

    function automatic int ci(input int t, input int i, input int c);
        return t * sop_pkg::N_LINE + 2 * i + c;
    endfunction : ci

    // Both polarities of input 2 keep a term false
    task automatic kill(input int t);
        fz[ci(t, 2, 0)] = 1'b1;
        fz[ci(t, 2, 1)] = 1'b1;
    endtask : kill

    task automatic end_sim();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim

    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        end_sim();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        logic [13:0] d;
        logic [7:0] r, v;
        core_clk = 1'b0; rst_b = 1'b0; oe_b = 1'b0; supply_ok = 1'b1;
        pl_load = 1'b0; pl_clear = 1'b0; pl_data = 8'h00; ded_in = '0;
        cfg_fuse = '0; fz = '0; ext_en = 8'h00; ext_val = 8'h00; d = '0;
        void'($urandom(32'h29CE));
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
        expect_out(8'h3C, 8'hFF, 8'hFF);
        expect_link(8'h00, 8'hFF);
        u_board.clock_pulse(1);
        expect_out(8'h00, 8'hFF, 8'hFF);
        $display("test unprogrammed done");
        @(posedge core_clk);
        oe_b <= 1'b1;
        expect_out(8'h00, 8'hC3, 8'hC3);
        supply_ok <= 1'b0;
        expect_out(8'h00, 8'h00, 8'h00);
        supply_ok <= 1'b1;
        oe_b <= 1'b0;
        pl_clear <= 1'b1;
        expect_out(8'h3C, 8'hFF, 8'h3C);
        expect_link(8'h00, 8'hFF);
        r = 8'($urandom);
        pl_clear <= 1'b0;
        pl_load <= 1'b1;
        pl_data <= r;
        expect_out(~r & 8'h3C, 8'hFF, 8'h3C);
        expect_link(~r, 8'hFF);
        pl_load <= 1'b0;
        $display("test enables and preload done");
        // Out 0 = d0 & d1, out 6 follows pin 1, out 2 toggles itself
        fz = '0;
        fz[ci(0, 0, 0)] = 1'b1;
        fz[ci(0, 1, 0)] = 1'b1;
        for (int t = 1; t < 8; t++) begin
            if (t < 7) begin
                kill(t);
                kill(48 + t);
            end
            kill(16 + t);
        end
        fz[ci(15, 3, 0)] = 1'b1;
        fz[ci(15, 3, 1)] = 1'b1;
        fz[ci(63, 4, 0)] = 1'b1;
        fz[ci(48, 13, 0)] = 1'b1;
        fz[ci(16, 14, 1)] = 1'b1;
        cfg_fuse <= fz;
        ext_en <= 8'h02;
        // Input 11 stays unconnected yet is randomised too
        for (int k = 0; k < 16; k++) begin
            @(posedge core_clk);
            d = 14'($urandom);
            v = 8'($urandom);
            ded_in <= d;
            ext_val <= v;
            expect_out({1'b0, ~v[1], 5'h00, ~(d[0] & d[1])},
                {d[4], 7'h7D}, 8'h41);
        end
        $display("test array terms done");
        @(posedge core_clk);
        oe_b <= 1'b1;
        u_board.clock_pulse(3);
        oe_b <= 1'b0;
        expect_out({5'h00, r[2], 2'h0}, {d[4], 7'h7D}, 8'h3C);
        u_board.clock_pulse(1);
        expect_out({5'h00, ~r[2], 2'h0}, {d[4], 7'h7D}, 8'h3C);
        $display("test register feedback done");
        #2;
        end_sim();
    end
endmodule : programmable_sop_array_tb_top

`default_nettype wire
